// ==== rtl/cbc_pkg.sv ====
// Purpose: Shared constants, types and helpers of the CPU bus control block
// Assumes: One 50 MHz core clock, asynchronous active-low reset
// Notes:   Port width codes select 32, 16 or 8 bit memory ports
package cbc_pkg;
  // ***************************************************************
  // Widths and sizes
  // ***************************************************************
  localparam int DATA_W      = 32;            // Multiplexed bus width
  localparam int BE_W        = 4;             // Byte lane enables
  localparam int FIFO_DEPTH  = 16;            // Read return buffer words
  localparam int CNT_W       = 5;             // Holds 0 .. FIFO_DEPTH
  localparam int PAGE_LSB    = 8;             // 256 byte page boundary
  localparam int PAGE_W      = DATA_W - PAGE_LSB;
  localparam logic [CNT_W-1:0] BURST_WORDS = 5'h04;   // Four word refill
  localparam logic [CNT_W-1:0] READ_ROOM   = 5'h0C;   // Max fill to start read

  // ***************************************************************
  // Encodings and reset values
  // ***************************************************************
  localparam logic [1:0]        PORT_32   = 2'h0;     // 32 bit port
  localparam logic [1:0]        PORT_16   = 2'h1;     // 16 bit port
  localparam logic [1:0]        PORT_8    = 2'h2;     // 8 bit port
  localparam logic [BE_W-1:0]   BE_NONE_N = 4'hF;     // All lanes off (active low)
  localparam logic [DATA_W-1:0] RST_WORD  = 32'h00000000;
  localparam logic [PAGE_W-1:0] RST_PAGE  = 24'h000000;
  localparam logic [1:0]        RST_BEATS = 2'h0;

  // Bus sequencer states, one-hot
  typedef enum logic [3:0] {
    CBC_IDLE = 4'h1,                          // No transfer
    CBC_ADDR = 4'h2,                          // Address phase, latch strobe
    CBC_TURN = 4'h4,                          // Second interval, bus turn
    CBC_DATA = 4'h8                           // Data phase, wait for ack
  } cbc_state_e;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  // Extra beats after the first for a port width
  function automatic logic [1:0] cbc_extra_beats(input logic [1:0] port);
    case (port)
      PORT_16: cbc_extra_beats = 2'h1;
      PORT_8:  cbc_extra_beats = 2'h3;
      default: cbc_extra_beats = 2'h0;
    endcase
  endfunction

  // Next datum of a narrow write, lower lanes first
  function automatic logic [DATA_W-1:0] cbc_next_datum(input logic [1:0]        port,
                                                       input logic [DATA_W-1:0] d);
    case (port)
      PORT_16: cbc_next_datum = {16'h0000, d[31:16]};
      PORT_8:  cbc_next_datum = {8'h00, d[31:8]};
      default: cbc_next_datum = d;
    endcase
  endfunction
endpackage : cbc_pkg

// ==== rtl/cbc_fifo_if.sv ====
// Purpose: Carrier between the bus sequencer and its read return FIFO
// Assumes: Both ends on core_clk
// Notes:   Valid and ready on both sides, fill level for admission
`timescale 1ns/1ps
interface cbc_fifo_if
  import cbc_pkg::*;
();
  logic              in_valid;                // Word offered to FIFO
  logic              in_ready;                // FIFO has room
  logic [DATA_W-1:0] in_data;                 // Word to store
  logic              out_valid;               // Head word present
  logic              out_ready;               // Consumer takes head
  logic [DATA_W-1:0] out_data;                // Head word, registered
  logic [CNT_W-1:0]  level;                   // Words in storage array

  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data, level);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data, level);
endinterface : cbc_fifo_if

// ==== rtl/cbc_fifo.sv ====
// Purpose: Read return FIFO with registered head word
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Array holds DEPTH words, plus one in the output register
`timescale 1ns/1ps
module cbc_fifo
  import cbc_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = FIFO_DEPTH
)(
  // Clock and reset
  input wire logic  core_clk,
  input wire logic  rstn,
  // FIFO ports
  cbc_fifo_if.fifo  f
);
  // ***************************************************************
  // Storage
  // ***************************************************************
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];              // Storage array
  logic [PTR_W-1:0] wr_ptr_r;                 // Write index
  logic [PTR_W-1:0] rd_ptr_r;                 // Read index
  logic [CNT_W-1:0] cnt_r;                    // Words in array
  logic             out_valid_r;              // Head register full
  logic [WIDTH-1:0] out_data_r;               // Head register
  logic             push;                     // Store this cycle
  logic             pop;                      // Move array head out

  assign f.in_ready  = (cnt_r != CNT_W'(DEPTH));
  assign push        = f.in_valid && f.in_ready;
  assign pop         = (cnt_r != '0) && (!out_valid_r || f.out_ready);
  assign f.out_valid = out_valid_r;
  assign f.out_data  = out_data_r;
  assign f.level     = cnt_r;

  // Array write, no reset needed on data
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wr_ptr_r] <= f.in_data;
  end

  // Pointers and fill count
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= PTR_W'(wr_ptr_r + 1'b1);
      if (pop)
        rd_ptr_r <= PTR_W'(rd_ptr_r + 1'b1);
      if (push && !pop)
        cnt_r <= CNT_W'(cnt_r + 1'b1);
      else if (pop && !push)
        cnt_r <= CNT_W'(cnt_r - 1'b1);
    end
  end

  // Registered head word
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end
    else if (pop)
    begin
      out_valid_r <= 1'b1;
      out_data_r  <= mem[rd_ptr_r];
    end
    else if (f.out_ready)
      out_valid_r <= 1'b0;
  end
endmodule : cbc_fifo

// ==== rtl/cbc_bus_ctrl.sv ====
// Purpose: Control signals of the multiplexed external memory bus
// Assumes: ack and read_buffer_capture arrive from outside, synchronised here
// Notes:   Read words pass a 16 word FIFO before reaching the core
//
// Summary of operation
// - Diag shows cache miss during address phase of reads
// - Diag shows instruction or data afterwards
// - Latch strobe marks valid address on bus
// - Release output once bus no longer driven
// - Burst requests four words on a read
// - Burst only on qualifying cache miss reads
// - Shared pin flags same page back-to-back writes
// - Read indicator during read transactions
// - Write indicator during write transactions
// - Write ack advances datum or ends cycle
// - Read ack releases data to core
// - Address phase then data phase per transfer
// - Byte enables on low four address bits, 32 bit ports only
`timescale 1ns/1ps
module cbc_bus_ctrl
  import cbc_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Core request
  input  wire logic              req_valid,
  output wire logic              req_ready,
  input  wire logic              req_write,
  input  wire logic [DATA_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [BE_W-1:0]   req_be,
  input  wire logic [1:0]        req_port,
  input  wire logic              req_miss,
  input  wire logic              req_instr,
  // Configuration
  input  wire logic              dcache_quad_refill,
  // Core read return
  output logic                   rd_done,
  output wire logic              rdata_valid,
  input  wire logic              rdata_ready,
  output wire logic [DATA_W-1:0] rdata,
  // Bus pins
  output logic [DATA_W-1:0]      ad_out,
  input  wire logic [DATA_W-1:0] ad_in,
  output logic                   ad_oe_n,
  output logic                   ale,
  output logic                   diag,
  output logic                   read_bus_release,
  output logic                   burst_near,
  output logic                   rd,
  output logic                   wr,
  input  wire logic              ack,
  input  wire logic              read_buffer_capture
);
  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [2:0]        ack_s_r;                 // Ack sync plus edge stage
  logic [2:0]        cap_s_r;                 // Capture sync plus edge stage
  logic [DATA_W-1:0] ad_s1_r;                 // Bus data first stage
  logic [DATA_W-1:0] ad_s2_r;                 // Bus data second stage
  logic              ack_edge;                // New acknowledge
  logic              cap_edge;                // New capture strobe

  // Two flip-flops per pin, third stage only for edge detection
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_s_r <= 3'h0;
      cap_s_r <= 3'h0;
      ad_s1_r <= RST_WORD;
      ad_s2_r <= RST_WORD;
    end
    else
    begin
      ack_s_r <= {ack_s_r[1:0], ack};
      cap_s_r <= {cap_s_r[1:0], read_buffer_capture};
      ad_s1_r <= ad_in;
      ad_s2_r <= ad_s1_r;
    end
  end

  assign ack_edge = ack_s_r[1] && !ack_s_r[2];
  assign cap_edge = cap_s_r[1] && !cap_s_r[2];

  // ***************************************************************
  // Read return FIFO
  // ***************************************************************
  cbc_fifo_if rf ();

  cbc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk (core_clk),
    .rstn     (rstn),
    .f        (rf)
  );

  // ***************************************************************
  // Transaction context
  // ***************************************************************
  cbc_state_e        state_r;                 // Sequencer state
  cbc_state_e        state_nxt;               // Next state
  logic              write_r;                 // Current is a write
  logic              miss_r;                  // Current read is a miss
  logic              instr_r;                 // Instruction reference
  logic              burst_r;                 // Four word read
  logic              near_r;                  // Same page write
  logic [1:0]        port_r;                  // Port width code
  logic [1:0]        beats_r;                 // Write beats left
  logic [DATA_W-1:0] wdata_r;                 // Current write datum
  logic [PAGE_W-1:0] last_page_r;             // Page of prior write
  logic              last_wr_r;               // Prior transaction a write
  logic              start;                   // Accept a core request
  logic              room;                    // FIFO can take a burst
  logic              finish;                  // Ack ends the transaction

  assign room      = (rf.level <= READ_ROOM);
  assign req_ready = (state_r == CBC_IDLE) && (req_write || room);
  assign start     = req_valid && req_ready;
  assign finish    = (state_r == CBC_DATA) && ack_edge && (write_r ? beats_r == 2'h0 : 1'b1);

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CBC_IDLE: if (start) state_nxt = CBC_ADDR;
      CBC_ADDR: state_nxt = CBC_TURN;
      CBC_TURN: state_nxt = CBC_DATA;
      CBC_DATA: if (finish) state_nxt = CBC_IDLE;
      default:  state_nxt = CBC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state_r <= CBC_IDLE;
    else
      state_r <= state_nxt;
  end

  // Capture request context, page tracking and write beats
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      write_r     <= 1'b0;
      miss_r      <= 1'b0;
      instr_r     <= 1'b0;
      burst_r     <= 1'b0;
      near_r      <= 1'b0;
      port_r      <= PORT_32;
      beats_r     <= RST_BEATS;
      wdata_r     <= RST_WORD;
      last_page_r <= RST_PAGE;
      last_wr_r   <= 1'b0;
    end
    else if (start)
    begin
      write_r   <= req_write;
      miss_r    <= req_miss;
      instr_r   <= req_instr;
      burst_r   <= !req_write && req_miss && (req_instr || dcache_quad_refill);
      near_r    <= req_write && last_wr_r &&
                   (req_addr[DATA_W-1:PAGE_LSB] == last_page_r);
      port_r    <= req_port;
      beats_r   <= req_write ? cbc_extra_beats(req_port) : RST_BEATS;
      wdata_r   <= req_wdata;
      last_wr_r <= req_write;
      if (req_write)
        last_page_r <= req_addr[DATA_W-1:PAGE_LSB];
    end
    else if ((state_r == CBC_DATA) && write_r && ack_edge && (beats_r != 2'h0))
    begin
      beats_r <= beats_r - 2'h1;
      wdata_r <= cbc_next_datum(port_r, wdata_r);
    end
  end

  // ***************************************************************
  // Registered pin outputs
  // ***************************************************************
  // Pins follow the next state so they line up with state_r
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ad_out           <= RST_WORD;
      ad_oe_n          <= 1'b1;
      ale              <= 1'b0;
      diag             <= 1'b0;
      read_bus_release <= 1'b0;
      burst_near       <= 1'b0;
      rd               <= 1'b0;
      wr               <= 1'b0;
    end
    else
    begin
      case (state_nxt)
        CBC_ADDR:
        begin
          // Address with byte lane enables, only 32 bit ports use them
          ad_out  <= {req_addr[DATA_W-1:BE_W],
                      (req_port == PORT_32) ? ~req_be : BE_NONE_N};
          ad_oe_n <= 1'b0;
          ale     <= 1'b1;
          diag    <= !req_write && req_miss;
          read_bus_release <= 1'b0;
          burst_near <= req_write ? (last_wr_r &&
                        (req_addr[DATA_W-1:PAGE_LSB] == last_page_r))
                        : (req_miss && (req_instr || dcache_quad_refill));
          rd      <= !req_write;
          wr      <= req_write;
        end
        CBC_TURN, CBC_DATA:
        begin
          // Writes drive data, reads release the bus
          ad_out  <= write_r ? wdata_r : RST_WORD;
          ad_oe_n <= !write_r;
          ale     <= 1'b0;
          diag    <= !write_r && instr_r;
          read_bus_release <= !write_r;
          burst_near <= write_r ? near_r : burst_r;
          rd      <= !write_r;
          wr      <= write_r;
        end
        default:
        begin
          // Idle bus, nothing driven
          ad_out  <= RST_WORD;
          ad_oe_n <= 1'b1;
          ale     <= 1'b0;
          diag    <= 1'b0;
          read_bus_release <= 1'b0;
          burst_near <= 1'b0;
          rd      <= 1'b0;
          wr      <= 1'b0;
        end
      endcase
    end
  end

  // ***************************************************************
  // Read data path
  // ***************************************************************
  // Captured words enter the FIFO only in the data phase of a read
  assign rf.in_valid  = (state_r == CBC_DATA) && !write_r && cap_edge;
  assign rf.in_data   = ad_s2_r;
  assign rf.out_ready = rdata_ready;
  assign rdata_valid  = rf.out_valid;
  assign rdata        = rf.out_data;

  // Read completion pulse lets the core consume its data
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rd_done <= 1'b0;
    else
      rd_done <= (state_r == CBC_DATA) && !write_r && ack_edge;
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  property p_rd_wr_excl;
    @(posedge core_clk) disable iff (!rstn) !(rd && wr);
  endproperty
  a_rd_wr_excl: assert property (p_rd_wr_excl) else $error("rd and wr together");

  property p_ale_addr;
    @(posedge core_clk) disable iff (!rstn)
      ale |-> (state_r == CBC_ADDR) && !ad_oe_n ##1 !ale && (state_r == CBC_TURN);
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("strobe not in address phase");

  property p_diag_miss;
    @(posedge core_clk) disable iff (!rstn) (ale && rd) |-> (diag == miss_r);
  endproperty
  a_diag_miss: assert property (p_diag_miss) else $error("diag not miss flag");

  property p_diag_instr;
    @(posedge core_clk) disable iff (!rstn)
      (rd && (state_r == CBC_TURN)) |-> (diag == instr_r);
  endproperty
  a_diag_instr: assert property (p_diag_instr) else $error("diag not instr flag");

  property p_release;
    @(posedge core_clk) disable iff (!rstn) read_bus_release |-> ad_oe_n && rd && !ale;
  endproperty
  a_release: assert property (p_release) else $error("release while driving");

  property p_burst_miss;
    @(posedge core_clk) disable iff (!rstn) (rd && burst_near) |-> miss_r;
  endproperty
  a_burst_miss: assert property (p_burst_miss) else $error("burst without miss");

  property p_burst_icache;
    @(posedge core_clk) disable iff (!rstn)
      (ale && rd && miss_r && instr_r) |-> burst_near [*3];
  endproperty
  a_burst_icache: assert property (p_burst_icache) else $error("icache miss no burst");

  property p_near_page;
    @(posedge core_clk) disable iff (!rstn)
      (ale && wr) |-> (burst_near == ($past(last_wr_r) &&
        (ad_out[DATA_W-1:PAGE_LSB] == $past(last_page_r))));
  endproperty
  a_near_page: assert property (p_near_page) else $error("near flag wrong for page");

  property p_write_end;
    @(posedge core_clk) disable iff (!rstn) finish |=> (state_r == CBC_IDLE) && !rd && !wr;
  endproperty
  a_write_end: assert property (p_write_end) else $error("ack did not end cycle");

  property p_rd_done;
    @(posedge core_clk) disable iff (!rstn)
      ((state_r == CBC_DATA) && !write_r && ack_edge) |=> rd_done ##1 !rd_done;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read ack not passed on");

  property p_be_lanes;
    @(posedge core_clk) disable iff (!rstn)
      (ale && (port_r != PORT_32)) |-> (ad_out[BE_W-1:0] == BE_NONE_N);
  endproperty
  a_be_lanes: assert property (p_be_lanes) else $error("lanes on narrow port");

  property p_indicators;
    @(posedge core_clk) disable iff (!rstn)
      (state_r != CBC_IDLE) |-> (rd == !write_r) && (wr == write_r);
  endproperty
  a_indicators: assert property (p_indicators) else $error("wrong direction pin");

  c_burst_read: cover property (@(posedge core_clk) disable iff (!rstn) rd && burst_near && ale);
  c_near_write: cover property (@(posedge core_clk) disable iff (!rstn) wr && burst_near && ale);
  c_narrow_wr:  cover property (@(posedge core_clk) disable iff (!rstn)
                                 wr && ack_edge && (beats_r != 2'h0));
  c_fifo_full:  cover property (@(posedge core_clk) disable iff (!rstn) !rf.in_ready);
endmodule : cbc_bus_ctrl

// ==== testbench/cbc_mem_model.sv ====
// Purpose: Memory system model on the far side of the bus pins
// Assumes: Samples the device pins at core_clk rising edges
// Notes:   Slow mode stretches the wait before each acknowledge
`timescale 1ns/1ps
module cbc_mem_model
  import cbc_pkg::*;
(
  // Clock and answer speed
  input  wire logic              core_clk,
  input  wire logic              slow,
  // Device bus outputs
  input  wire logic [DATA_W-1:0] ad_out,
  input  wire logic              ale,
  input  wire logic              rd,
  input  wire logic              wr,
  input  wire logic              burst_near,
  input  wire logic              read_bus_release,
  // Memory answers
  output logic [DATA_W-1:0]      ad_in,
  output logic                   ack,
  output logic                   read_buffer_capture
);
  logic [DATA_W-1:0] addr_l;   // Latched transfer address
  logic [DATA_W-1:0] last_d;   // Bus value at last ack
  int                beats;    // Acks in last transfer

  // One ack pulse, low again before the next beat
  task automatic ack_pulse();
    repeat (slow ? 6 : 1) @(posedge core_clk);
    ack <= 1'h1;
    last_d = ad_out;
    beats++;
    repeat (3) @(posedge core_clk);
    ack <= 1'h0;
    repeat (5) @(posedge core_clk);
  endtask

  // Read words, driven only once the device let go
  task automatic give_read(input int n);
    int k;
    k = 0;
    while (read_bus_release !== 1'h1 && k < 20)
    begin
      @(posedge core_clk);
      k++;
    end
    for (int j = 0; j < n; j++)
    begin
      ad_in <= {addr_l[31:4], 2'(j), 2'h0};
      @(posedge core_clk);
      read_buffer_capture <= 1'h1;
      repeat (3) @(posedge core_clk);
      read_buffer_capture <= 1'h0;
      repeat (3) @(posedge core_clk);
    end
    ad_in <= ~ad_in; // Released bus shows no stale word
    ack_pulse();
  endtask

  // Answer each address phase
  initial
  begin
    ad_in = 32'h5A5A_A5A5;
    ack = 1'h0;
    read_buffer_capture = 1'h0;
    beats = 0;
    forever
    begin
      @(posedge core_clk);
      if (ale === 1'h1)
      begin
        addr_l = ad_out;
        beats = 0;
        if (rd === 1'h1)
          give_read(burst_near === 1'h1 ? 4 : 1);
        else
          for (int b = 0; b < 8 && wr === 1'h1; b++)
            ack_pulse();
      end
    end
  end
endmodule // cbc_mem_model

// ==== testbench/test_cpu_bus_control_signals.sv ====
// Purpose: Self-checking bench of the bus control block
// Assumes: Memory model answers every transfer
// Notes:   Table rows for reads and writes, FIFO fill by hand
`timescale 1ns/1ps
module test_cpu_bus_control_signals
  import cbc_pkg::*;
  ;
  localparam logic [31:0] WDATA = 32'hA5C3_0F96;  // Write word
  // Row: request fields, then expected burst/near and read word or write beat count
  typedef struct packed {
    logic w; logic [1:0] p; logic m; logic i; logic q; logic bn; logic [2:0] nb; logic [31:0] a;
  } cbc_row_s;
  cbc_row_s rows [9];
  logic core_clk, rstn, req_valid, req_ready, req_write, req_miss, req_instr, slow;
  logic dcache_quad_refill, rd_done, rdata_valid, rdata_ready, ale, diag, ad_oe_n;
  logic read_bus_release, burst_near, rd, wr, ack, read_buffer_capture;
  logic [31:0] req_addr, req_wdata, rdata, ad_out, ad_in;
  logic [3:0]  req_be;
  logic [1:0]  req_port;
  int          n_errors, cmp_count;

  cbc_bus_ctrl dut_u (.core_clk, .rstn, .req_valid, .req_ready, .req_write, .req_addr,
    .req_wdata, .req_be, .req_port, .req_miss, .req_instr, .dcache_quad_refill, .rd_done,
    .rdata_valid, .rdata_ready, .rdata, .ad_out, .ad_in, .ad_oe_n, .ale, .diag,
    .read_bus_release, .burst_near, .rd, .wr, .ack, .read_buffer_capture);
  cbc_mem_model mem_u (.core_clk, .slow, .ad_out, .ale, .rd, .wr, .burst_near,
    .read_bus_release, .ad_in, .ack, .read_buffer_capture);

  initial
  begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("compares=%0d mismatches=%0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic give_up();
    n_errors++;
    end_of_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Take n words from the read return, starting at a posedge
  task automatic drain(input logic [31:0] a, input int n);
    int got, k;
    got = 0;
    k = 0;
    rdata_ready <= 1'h1;
    while (got < n && k++ < 100)
    begin
      @(negedge core_clk);
      if (rdata_valid === 1'h1)
      begin
        chk(rdata, {a[31:4], 2'(got), 2'h0});
        got++;
      end
      @(posedge core_clk);
    end
    if (got < n) give_up();
  endtask

  task automatic drained();
    @(negedge core_clk);
    chk(rdata_valid, 1'h0);
    @(posedge core_clk);
    rdata_ready <= 1'h0;
  endtask

  // One transfer, checked phase by phase
  task automatic run(input cbc_row_s r, input bit dr);
    int k, sh;
    req_valid <= 1'h1;
    req_write <= r.w;
    req_addr <= r.a;
    req_port <= r.p;
    req_miss <= r.m;
    req_instr <= r.i;
    dcache_quad_refill <= r.q;
    k = 0;
    do @(negedge core_clk); while (req_ready !== 1'h1 && k++ < 50);
    @(posedge core_clk);
    req_valid <= 1'h0;
    do @(negedge core_clk); while (ale !== 1'h1 && k++ < 60);
    if (k > 60) give_up();
    chk({rd, wr}, {~r.w, r.w});
    chk(burst_near, r.bn);
    chk(ad_out, {r.a[31:4], r.p == PORT_32 ? 4'h9 : BE_NONE_N});
    if (!r.w) chk(diag, r.m);
    @(negedge core_clk);
    chk({ale, ad_oe_n}, {1'h0, ~r.w});
    if (r.w) chk(ad_out, WDATA);
    else chk({diag, read_bus_release}, {r.i, 1'h1});
    k = 0;
    do @(negedge core_clk); while ((r.w ? wr : ~rd_done) !== 1'h0 && k++ < 300);
    if (k > 300) give_up();
    sh = r.nb == 3'h4 ? 24 : r.nb == 3'h2 ? 16 : 0;
    chk(32'(mem_u.beats), r.w ? 32'(r.nb) : 32'h1);
    if (r.w) chk(mem_u.last_d, WDATA >> sh);
    @(posedge core_clk);
    if (!r.w && dr)
    begin
      drain(r.a, r.nb);
      drained();
    end
  endtask

  initial
  begin
    rows = '{
      '{1'h0, PORT_32, 1'h1, 1'h1, 1'h0, 1'h1, 3'h4, 32'h1000_0040},
      '{1'h0, PORT_32, 1'h1, 1'h0, 1'h0, 1'h0, 3'h1, 32'h1000_0080},
      '{1'h0, PORT_32, 1'h1, 1'h0, 1'h1, 1'h1, 3'h4, 32'h1000_00C0},
      '{1'h0, PORT_32, 1'h0, 1'h1, 1'h1, 1'h0, 3'h1, 32'h1000_0100},
      '{1'h1, PORT_32, 1'h0, 1'h0, 1'h0, 1'h0, 3'h1, 32'h2000_0100},
      '{1'h1, PORT_16, 1'h0, 1'h0, 1'h0, 1'h1, 3'h2, 32'h2000_01F0},
      '{1'h1, PORT_8,  1'h0, 1'h0, 1'h0, 1'h0, 3'h4, 32'h2000_0200},
      '{1'h1, PORT_32, 1'h0, 1'h0, 1'h0, 1'h1, 3'h1, 32'h2000_02FC},
      '{1'h0, PORT_16, 1'h1, 1'h1, 1'h0, 1'h1, 3'h4, 32'h1000_0200}};
    {rstn, req_valid, req_write, req_miss, req_instr, slow} = 6'h00;
    {dcache_quad_refill, rdata_ready, req_port} = 4'h0;
    req_addr = 32'h0000_0000;
    req_wdata = WDATA;
    req_be = 4'h6;
    n_errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge core_clk);
    chk({ale, rd, wr, burst_near, read_bus_release, ad_oe_n}, 32'h1);
    rstn <= 1'h1;
    @(negedge core_clk);
    chk(req_ready, 1'h1);
    $display("reset test done");
    for (int n = 0; n < 9; n++)
    begin
      @(posedge core_clk);
      slow <= n[0];
      run(rows[n], 1'h1);
      repeat (8) @(posedge core_clk);
      $display("row %0d done", n);
    end
    for (int n = 0; n < 4; n++)
    begin
      @(posedge core_clk);
      run('{1'h0, PORT_32, 1'h1, 1'h1, 1'h0, 1'h1, 3'h4, 32'h3000_0000 + 32'(n * 16)}, 1'h0);
      repeat (8) @(posedge core_clk);
    end
    @(negedge core_clk);
    chk(req_ready, 1'h0);
    @(posedge core_clk);
    for (int n = 0; n < 4; n++)
      drain(32'h3000_0000 + 32'(n * 16), 4);
    drained();
    $display("fill test done");
    end_of_test();
  end
endmodule // test_cpu_bus_control_signals
